// [rtl/ncl_pkg.sv]
// shared constants and carrier types for the non-maskable interrupt cause logger
package ncl_pkg;

    // bit positions inside the interrupt cause record
    localparam int NCL_POS_OSC = 0;
    localparam int NCL_POS_TAMPER = 1;
    localparam int NCL_POS_WDOG = 2;
    localparam int NCL_POS_BROWN = 3;
    localparam int NCL_POS_PIN = 4;
    localparam int NCL_NUM_SRC = 5;

    // reset values
    localparam logic [4:0] NCL_CAUSE_RST = 5'h00;
    localparam logic [1:0] NCL_TAMPER_RST = 2'h0;

    // tamper state field encodings
    localparam logic [1:0] NCL_TAMPER_IDLE = 2'h0;
    localparam logic [1:0] NCL_TAMPER_SEEN = 2'h2;

    // raw event sources, one bit each
    typedef struct packed {
        logic pin;
        logic brown;
        logic wdog;
        logic tamper;
        logic osc;
    } ncl_src_t;

    // status seen by software
    typedef struct packed {
        logic [4:0] interruptCause;
        logic oscFailRawFlag;
        logic brownoutRawFlag;
        logic watchdogRawFlag;
        logic [1:0] tamperState;
        logic portRawFlag;
        logic resetCauseWdog;
    } ncl_stat_t;

endpackage

// [rtl/ncl_sticky.sv]
// one sticky status flag: set wins over clear
`timescale 1ns/1ps
module ncl_sticky
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic setPulse,
    input wire logic clrPulse,
    output logic flag
);
    logic flag_reg;
    logic flag_next;

    // next value: a set in the clearing cycle is not lost
    always_comb
    begin
        flag_next = flag_reg;
        if (setPulse)
        begin
            flag_next = 1'b1;
        end
        else if (clrPulse)
        begin
            flag_next = 1'b0;
        end
    end

    // register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule

// [rtl/ncl_nmi_cause_logging.sv]
// non-maskable interrupt cause logger with per-source raw flags
`timescale 1ns/1ps
module ncl_nmi_cause_logging
    import ncl_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire ncl_src_t srcEvent,
    input wire logic wdogResetMode,
    input wire logic nmiPinAsync,
    input wire logic pinIrqEnable,
    input wire logic [4:0] causeClearMask,
    input wire logic causeClearStrobe,
    input wire logic rawClearOsc,
    input wire logic rawClearBrown,
    input wire logic rawClearWdog,
    input wire logic rawClearPort,
    input wire logic tamperClear,
    input wire logic resetCauseClear,
    input wire logic wdogResetSeen,
    output ncl_stat_t status,
    output logic nmiOut,
    output logic portIrq
);
    // pin synchroniser, first stage read only by second
    logic pinMeta_reg;
    logic pinSync_reg;
    logic pinPrev_reg;
    // effective event pulses
    ncl_src_t evt;
    logic pinRise;
    logic wdogNmi;
    logic [4:0] causeSet;
    logic [4:0] causeClr;
    logic [4:0] causeQ;
    logic oscRaw;
    logic brownRaw;
    logic wdogRaw;
    logic portRaw;
    logic rescWdog;
    logic [1:0] tamperState_reg;
    logic [1:0] tamperState_next;
    ncl_stat_t status_reg;
    ncl_stat_t status_next;
    logic nmiOut_reg;
    logic nmiOut_next;
    logic portIrq_reg;
    logic portIrq_next;

    // synchroniser registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pinMeta_reg <= 1'b0;
            pinSync_reg <= 1'b0;
            pinPrev_reg <= 1'b0;
        end
        else
        begin
            pinMeta_reg <= nmiPinAsync;
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end

    // event decode
    always_comb
    begin
        pinRise = pinSync_reg & ~pinPrev_reg;
        // expiry that resets the chip is not an interrupt cause
        wdogNmi = srcEvent.wdog & ~wdogResetMode;
        evt = srcEvent;
        evt.wdog = wdogNmi;
        evt.pin = pinRise;
        causeSet = {evt.pin, evt.brown, evt.wdog, evt.tamper, evt.osc};
        // write-one-to-clear; watchdog bit included
        causeClr = causeClearStrobe ? causeClearMask : 5'h00;
    end

    // one sticky flag per cause bit
    genvar gi;
    generate
        for (gi = 0; gi < NCL_NUM_SRC; gi++)
        begin : g_cause
            ncl_sticky u_cause
            (
                .core_clk(core_clk),
                .srst(srst),
                .setPulse(causeSet[gi]),
                .clrPulse(causeClr[gi]),
                .flag(causeQ[gi])
            );
        end
    endgenerate

    // raw status flags, independent of the cause record
    ncl_sticky u_osc_raw
    (
        .core_clk(core_clk),
        .srst(srst),
        .setPulse(srcEvent.osc),
        .clrPulse(rawClearOsc),
        .flag(oscRaw)
    );
    ncl_sticky u_brown_raw
    (
        .core_clk(core_clk),
        .srst(srst),
        .setPulse(srcEvent.brown),
        .clrPulse(rawClearBrown),
        .flag(brownRaw)
    );
    // raw flag follows every timeout, reset mode or not
    ncl_sticky u_wdog_raw
    (
        .core_clk(core_clk),
        .srst(srst),
        .setPulse(srcEvent.wdog),
        .clrPulse(rawClearWdog),
        .flag(wdogRaw)
    );
    // port raw status is only set when software armed the pin
    ncl_sticky u_port_raw
    (
        .core_clk(core_clk),
        .srst(srst),
        .setPulse(pinRise & pinIrqEnable),
        .clrPulse(rawClearPort),
        .flag(portRaw)
    );
    // reset cause: srst must not wipe it in a real chip, so the
    // caller raises wdogResetSeen after the reset it caused
    ncl_sticky u_reset_cause_reg_wdog
    (
        .core_clk(core_clk),
        .srst(1'b0),
        .setPulse(wdogResetSeen),
        .clrPulse(resetCauseClear),
        .flag(rescWdog)
    );

    // tamper state field next value
    always_comb
    begin
        tamperState_next = tamperState_reg;
        if (srcEvent.tamper)
        begin
            tamperState_next = NCL_TAMPER_SEEN;
        end
        else if (tamperClear)
        begin
            tamperState_next = NCL_TAMPER_IDLE;
        end
    end

    // output assembly
    always_comb
    begin
        status_next.interruptCause = causeQ;
        status_next.oscFailRawFlag = oscRaw;
        status_next.brownoutRawFlag = brownRaw;
        status_next.watchdogRawFlag = wdogRaw;
        status_next.tamperState = tamperState_reg;
        status_next.portRawFlag = portRaw;
        status_next.resetCauseWdog = rescWdog;
        nmiOut_next = |causeQ;
        portIrq_next = portRaw;
    end

    // output and tamper registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tamperState_reg <= NCL_TAMPER_RST;
            status_reg <= '0;
            // reset cause stays visible through any reset that follows it
            status_reg.resetCauseWdog <= rescWdog;
            nmiOut_reg <= 1'b0;
            portIrq_reg <= 1'b0;
        end
        else
        begin
            tamperState_reg <= tamperState_next;
            status_reg <= status_next;
            nmiOut_reg <= nmiOut_next;
            portIrq_reg <= portIrq_next;
        end
    end

    assign status = status_reg;
    assign nmiOut = nmiOut_reg;
    assign portIrq = portIrq_reg;

    // assertions
    a_wdog_reset_nocause: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.wdog && wdogResetMode && !status.interruptCause[NCL_POS_WDOG]
        && !causeQ[NCL_POS_WDOG] |-> ##2 !status.interruptCause[NCL_POS_WDOG])
        else $error("watchdog reset set cause bit");
    a_wdog_nmi_cause: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.wdog && !wdogResetMode |-> ##2 status.interruptCause[NCL_POS_WDOG])
        else $error("watchdog cause missing");
    a_cause_clear_wdog: assert property (@(posedge core_clk) disable iff (srst)
        causeClearStrobe && causeClearMask[NCL_POS_WDOG] && !causeSet[NCL_POS_WDOG]
        |-> ##2 !status.interruptCause[NCL_POS_WDOG])
        else $error("watchdog cause not cleared");
    a_reset_cause_reg_wdog_set: assert property (@(posedge core_clk)
        wdogResetSeen |-> ##2 status.resetCauseWdog)
        else $error("reset cause watchdog missing");
    a_osc_raw_set: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.osc |-> ##2 status.oscFailRawFlag && status.interruptCause[NCL_POS_OSC])
        else $error("oscillator raw flag missing");
    a_brown_raw_set: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.brown |-> ##2 status.brownoutRawFlag)
        else $error("brownout raw flag missing");
    a_wdog_raw_set: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.wdog |-> ##2 status.watchdogRawFlag)
        else $error("watchdog raw flag missing");
    a_tamper_state_set: assert property (@(posedge core_clk) disable iff (srst)
        srcEvent.tamper |-> ##2 status.tamperState == NCL_TAMPER_SEEN)
        else $error("tamper state not shown");
    a_pin_port_raw: assert property (@(posedge core_clk) disable iff (srst)
        $rose(pinSync_reg) && pinIrqEnable |-> ##2 (portIrq && status.portRawFlag))
        else $error("port raw flag missing");
    a_pin_cause: assert property (@(posedge core_clk) disable iff (srst)
        $rose(pinSync_reg) |-> ##2 status.interruptCause[NCL_POS_PIN])
        else $error("pin cause missing");
endmodule

// [bench/test_nmi_cause_logging.sv]
// self-checking bench for the interrupt cause logger
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module test_nmi_cause_logging;
    import ncl_pkg::*;
    logic core_clk = 1'b0; // 100 ns period
    logic srst = 1'b1;
    ncl_src_t srcEvent = '0;
    logic wdogResetMode = 1'b0;
    logic nmiPinAsync = 1'b0;
    logic pinIrqEnable = 1'b0;
    logic [4:0] causeClearMask = 5'h00;
    logic causeClearStrobe = 1'b0;
    logic rawClear = 1'b0; // shared by every raw and tamper clear
    logic resetCauseClear = 1'b0;
    logic wdogResetSeen = 1'b0;
    ncl_stat_t status;
    logic nmiOut;
    logic portIrq;
    int fail_count = 0;
    int total_checks = 0;

    ncl_nmi_cause_logging dut (.core_clk(core_clk), .srst(srst), .srcEvent(srcEvent),
        .wdogResetMode(wdogResetMode), .nmiPinAsync(nmiPinAsync), .pinIrqEnable(pinIrqEnable),
        .causeClearMask(causeClearMask), .causeClearStrobe(causeClearStrobe),
        .rawClearOsc(rawClear), .rawClearBrown(rawClear), .rawClearWdog(rawClear),
        .rawClearPort(rawClear), .tamperClear(rawClear), .resetCauseClear(resetCauseClear),
        .wdogResetSeen(wdogResetSeen), .status(status), .nmiOut(nmiOut), .portIrq(portIrq));

    // clock
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    // one-cycle event, then wait for the registered status
    task automatic pulse(input ncl_src_t e, input logic [4:0] clr);
        @(posedge core_clk);
        srcEvent <= e;
        causeClearMask <= clr;
        causeClearStrobe <= |clr;
        @(posedge core_clk);
        srcEvent <= '0;
        causeClearStrobe <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    // wipe every interrupt cause, raw and tamper flag so scenarios start clean
    task automatic clear_all();
        @(posedge core_clk);
        rawClear <= 1'b1;
        causeClearMask <= 5'h1f;
        causeClearStrobe <= 1'b1;
        @(posedge core_clk);
        rawClear <= 1'b0;
        causeClearStrobe <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("cause clear", 5'h00, status.interruptCause)
        `CHK("nmi idle", 1'b0, nmiOut)
        `CHK("raw clear", 6'h00, {status.oscFailRawFlag, status.brownoutRawFlag,
            status.watchdogRawFlag, status.tamperState, status.portRawFlag})
    endtask

    // one source per run: cause bit and its raw mirror
    task automatic one_source(input int pos, input logic [4:0] expRaw);
        ncl_src_t e;
        e = ncl_src_t'(5'h01 << pos);
        pulse(e, 5'h00);
        `CHK("cause bit", 5'h01 << pos, status.interruptCause)
        `CHK("nmi out", 1'b1, nmiOut)
        `CHK("raw mirrors", expRaw, {status.oscFailRawFlag, status.brownoutRawFlag,
            status.watchdogRawFlag, status.tamperState})
        clear_all();
    endtask

    // watchdog set/clear collisions and expiry-as-reset
    task automatic wdog_cases();
        pulse(ncl_src_t'(5'h04), 5'h04);
        `CHK("set beats clear", 5'h04, status.interruptCause)
        pulse('0, 5'h04);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("wdog held clear", 5'h00, status.interruptCause)
        // watchdog raw flag is still set by the first pulse; drop it first
        clear_all();
        @(posedge core_clk);
        wdogResetMode <= 1'b1;
        pulse(ncl_src_t'(5'h04), 5'h00);
        `CHK("no wdog cause", 5'h00, status.interruptCause)
        `CHK("wdog raw flag", 1'b1, status.watchdogRawFlag)
        // the expiry resets the chip; reset cause is raised after release
        @(posedge core_clk);
        srst <= 1'b1;
        wdogResetMode <= 1'b0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        wdogResetSeen <= 1'b1;
        @(posedge core_clk);
        wdogResetSeen <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("reset cause", 1'b1, status.resetCauseWdog)
        `CHK("cause after reset", 5'h00, status.interruptCause)
        // a later reset must not wipe the reset cause
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("reset cause kept", 1'b1, status.resetCauseWdog)
        @(posedge core_clk);
        srst <= 1'b0;
        resetCauseClear <= 1'b1;
        @(posedge core_clk);
        resetCauseClear <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("reset cause cleared", 1'b0, status.resetCauseWdog)
        clear_all();
    endtask

    // external pin, with and without port interrupt enabled
    task automatic pin_case(input logic en);
        @(posedge core_clk);
        pinIrqEnable <= en;
        nmiPinAsync <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        `CHK("pin cause", 5'h10, status.interruptCause)
        `CHK("port raw", en, status.portRawFlag)
        `CHK("port irq", en, portIrq)
        @(posedge core_clk);
        nmiPinAsync <= 1'b0;
        clear_all();
    endtask

    // verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, far beyond the roughly 100 cycles used
    initial
    begin
        #(3000 * 100);
        fail_count++;
        stop_test();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        resetCauseClear <= 1'b1;
        @(posedge core_clk);
        resetCauseClear <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        `CHK("reset status", 12'h000, status)
        one_source(NCL_POS_OSC, {3'b100, NCL_TAMPER_IDLE});
        one_source(NCL_POS_BROWN, {3'b010, NCL_TAMPER_IDLE});
        one_source(NCL_POS_WDOG, {3'b001, NCL_TAMPER_IDLE});
        one_source(NCL_POS_TAMPER, {3'b000, NCL_TAMPER_SEEN});
        wdog_cases();
        pin_case(1'b1);
        pin_case(1'b0);
        stop_test();
    end
endmodule
